// ### cpi_pkg.sv
// constants and types for the cam profile interpolator
package cpi_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CAMSEL = 12'h004;
    localparam logic [11:0] OFF_STROKE = 12'h008;
    localparam logic [11:0] OFF_LEN = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_POS = 12'h014;
    localparam logic [11:0] OFF_FEED = 12'h018;
    localparam logic [11:0] OFF_STDPOS = 12'h01c;
    localparam logic [11:0] OFF_TADDR = 12'h020;
    localparam logic [11:0] OFF_TDATA = 12'h024;
    localparam logic [11:0] OFF_CFG1 = 12'h044;
    localparam logic [11:0] OFF_CFG8 = 12'h060;
    // ****************************************
    // cam config word fields
    // ****************************************
    localparam int CFG_METH_LSB = 0;
    localparam int CFG_RES_LSB = 2;
    localparam int CFG_START_LSB = 4;
    localparam int CFG_NPTS_LSB = 15;
    localparam int CFG_W = 26;
    localparam logic [1:0] METH_STROKE = 2'h1;
    localparam logic [1:0] METH_COORD = 2'h2;
    localparam logic [3:0] MAX_CAM = 4'h8;
    // ****************************************
    // arithmetic and reset values
    // ****************************************
    localparam logic signed [63:0] RATIO_FULL = 64'sh0000_0000_0001_86a0;
    localparam logic signed [63:0] COORD_SCALE = 64'sh0000_0000_0000_03e8;
    localparam logic [6:0] DIV_STEPS = 7'h40;
    localparam logic [31:0] LEN_RST = 32'h0000_1000;
    localparam int TBL_WORDS = 2048;
    localparam logic [2:0] PH_START = 3'h0;
    localparam logic [2:0] PH_IDX = 3'h1;
    localparam logic [2:0] PH_FRAC = 3'h2;
    localparam logic [2:0] PH_RAT = 3'h3;
    localparam logic [2:0] PH_SEG = 3'h4;
    localparam logic [2:0] PH_CY = 3'h5;
    localparam logic [2:0] PH_VAL = 3'h6;
    localparam logic [1:0] JOB_FEED = 2'h0;
    localparam logic [1:0] JOB_WL = 2'h1;
    localparam logic [1:0] JOB_W0 = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LOAD = 5'h02,
        ST_SCAN = 5'h04,
        ST_DIV = 5'h08,
        ST_DONE = 5'h10
    } cpi_st_e_t;

    typedef struct packed {
        cpi_st_e_t st;
        logic [2:0] ph;
        logic [1:0] job;
        logic cmd;
        logic cmd_d;
        logic err;
        logic [3:0] sel;
        logic [31:0] stroke;
        logic [31:0] len;
        logic [3:0] cam;
        logic signed [31:0] stk;
        logic [8:1][CFG_W-1:0] cfg;
        logic [13:0] taddr;
        logic [31:0] rdata;
        logic [31:0] pos;
        logic wrp;
        logic signed [7:0] wcnt;
        logic wneg;
        logic signed [31:0] std;
        logic signed [31:0] feed;
        logic fvld;
        logic [31:0] q;
        logic signed [31:0] tmp;
        logic [10:0] idx;
        logic signed [63:0] acc;
        logic [63:0] dvd;
        logic [63:0] dvs;
        logic [63:0] rem;
        logic [6:0] cnt;
        logic neg;
    } cpi_state_t;
endpackage

// ### cpi_cam_interp.sv
// cam profile interpolator: apb registers, cycle position and cam evaluation
// Functional notes
// - cam zero runs straight line to 100%
// - cams one to eight are user tables
// - method code picks stroke or coordinate evaluation
// - stroke table resolution 256, 512, 1024, 2048
// - stroke ratios clamp to plus/minus 100.000
// - feed is standard plus stroke times ratio
// - interpolate between neighbouring table points
// - wrap adds stroke times last ratio
// - start index maps table point to zero
// - command edge latches cam and stroke
// - standard position moves only at wrap
// - coordinate table holds 2 to 1024 points
// - extrapolate from nearest two points
// - coordinate feed is standard plus output
// - coordinate wrap adds output difference
// - coordinate mode latches only cam number
// - cycle length is a configured travel
`timescale 1ns/1ps
module cpi_cam_interp (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic signed [31:0] axis_step_i,
    input wire logic axis_step_vld_i,
    output logic [31:0] cyc_pos_o,
    output logic [31:0] feed_pos_o,
    output logic feed_vld_o,
    output logic wrap_o,
    output logic [31:0] std_pos_o
);
    // ****************************************
    // state and table memory
    // ****************************************
    cpi_pkg::cpi_state_t r;
    cpi_pkg::cpi_state_t n;
    // table words stay out of the state struct: too large for a packed register
    logic signed [31:0] mem [0:8*cpi_pkg::TBL_WORDS-1];

    localparam int CFG_W_L = cpi_pkg::CFG_W;
    logic [CFG_W_L-1:0] ccfg;
    logic [13:0] base;
    logic [11:0] res_n;
    logic [10:0] start;
    logic [10:0] npts;
    logic cfg_hit;
    logic [2:0] cfg_k;
    logic apb_wr;
    logic rise;

    function automatic logic signed [31:0] sat(input logic signed [31:0] v);
        if (v > 32'sh0001_86a0) begin
            return 32'sh0001_86a0;
        end else if (v < -32'sh0001_86a0) begin
            return -32'sh0001_86a0;
        end
        return v;
    endfunction

    // extended stroke table: points past the end continue one cycle up
    function automatic logic signed [31:0] tval(input logic [12:0] k);
        logic [13:0] kk;
        kk = {1'b0, k};
        if (kk < {2'b00, res_n}) begin
            return sat(mem[base + kk]);
        end
        return sat(mem[base + kk - {2'b00, res_n}]) + sat(mem[base + {2'b00, res_n} - 14'h001]);
    endfunction

    function automatic logic [1:0] meth(input logic [CFG_W_L-1:0] c);
        return c[cpi_pkg::CFG_METH_LSB +: 2];
    endfunction

    assign ccfg = (r.cam == 4'h0) ? '0 : r.cfg[r.cam[3:0]];
    assign base = {r.cam[2:0] - 3'h1, 11'h000};
    assign res_n = 12'h100 << ccfg[cpi_pkg::CFG_RES_LSB +: 2];
    assign start = ccfg[cpi_pkg::CFG_START_LSB +: 11];
    assign npts = ccfg[cpi_pkg::CFG_NPTS_LSB +: 11];
    assign cfg_hit = paddr_i >= cpi_pkg::OFF_CFG1 && paddr_i <= cpi_pkg::OFF_CFG8
        && paddr_i[1:0] == 2'h0;
    assign cfg_k = 3'(paddr_i[4:2] - 3'h1);
    assign apb_wr = psel_i && penable_i && pwrite_i && !pslverr_o;
    assign rise = r.cmd && !r.cmd_d;

    // ****************************************
    // apb handshake
    // ****************************************
    assign pready_o = 1'b1;
    always_comb begin
        case (paddr_i)
            cpi_pkg::OFF_CTRL, cpi_pkg::OFF_CAMSEL, cpi_pkg::OFF_STROKE, cpi_pkg::OFF_LEN,
            cpi_pkg::OFF_STATUS, cpi_pkg::OFF_POS, cpi_pkg::OFF_FEED, cpi_pkg::OFF_STDPOS,
            cpi_pkg::OFF_TADDR, cpi_pkg::OFF_TDATA: pslverr_o = 1'b0;
            default: pslverr_o = psel_i && penable_i && !cfg_hit;
        endcase
    end

    assign prdata_o = r.rdata;
    assign cyc_pos_o = r.pos;
    assign feed_pos_o = r.feed;
    assign feed_vld_o = r.fvld;
    assign wrap_o = r.wrp;
    assign std_pos_o = r.std;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic signed [33:0] sum;
        logic signed [7:0] wd;
        logic signed [63:0] num;
        logic [63:0] den;
        logic go;
        logic signed [63:0] qs;
        logic signed [31:0] r0;
        logic signed [31:0] r1;
        logic [64:0] tr;
        logic [12:0] k;
        logic [13:0] cx;
        n = r;
        sum = '0;
        wd = '0;
        num = '0;
        den = '0;
        go = 1'b0;
        qs = r.neg ? -$signed(r.dvd) : $signed(r.dvd);
        r0 = '0;
        r1 = '0;
        tr = '0;
        k = '0;
        cx = base + {2'b00, r.idx, 1'b0};
        n.fvld = 1'b0;
        n.wrp = 1'b0;
        n.cmd_d = r.cmd;
        if (psel_i && !penable_i) begin
            case (paddr_i)
                cpi_pkg::OFF_CTRL: n.rdata = {31'h0, r.cmd};
                cpi_pkg::OFF_CAMSEL: n.rdata = {28'h0, r.sel};
                cpi_pkg::OFF_STROKE: n.rdata = r.stroke;
                cpi_pkg::OFF_LEN: n.rdata = r.len;
                cpi_pkg::OFF_STATUS: n.rdata = {22'h0, r.st, r.cam, r.err};
                cpi_pkg::OFF_POS: n.rdata = r.pos;
                cpi_pkg::OFF_FEED: n.rdata = r.feed;
                cpi_pkg::OFF_STDPOS: n.rdata = r.std;
                cpi_pkg::OFF_TADDR: n.rdata = {18'h0, r.taddr};
                cpi_pkg::OFF_TDATA: n.rdata = mem[r.taddr];
                default: n.rdata = cfg_hit ? {6'h0, r.cfg[{1'b0, cfg_k} + 4'h1]} : 32'h0;
            endcase
        end
        if (apb_wr) begin
            case (paddr_i)
                cpi_pkg::OFF_CTRL: n.cmd = pwdata_i[0];
                cpi_pkg::OFF_CAMSEL: n.sel = pwdata_i[3:0];
                cpi_pkg::OFF_STROKE: n.stroke = pwdata_i;
                cpi_pkg::OFF_LEN: n.len = pwdata_i;
                cpi_pkg::OFF_STATUS: n.err = r.err && !pwdata_i[0];
                cpi_pkg::OFF_TADDR: n.taddr = pwdata_i[13:0];
                cpi_pkg::OFF_TDATA: n.taddr = r.taddr + 14'h001;
                default: begin
                    // read-only registers fall here too: only config words take the write
                    if (cfg_hit) begin
                        n.cfg[{1'b0, cfg_k} + 4'h1] = pwdata_i[CFG_W_L-1:0];
                    end
                end
            endcase
        end
        // command edge; an error raised here beats a same-cycle clear
        if (rise) begin
            if (r.sel > cpi_pkg::MAX_CAM) begin
                n.err = 1'b1;
            end else begin
                n.cam = r.sel;
                if (r.sel == 4'h0 || meth(r.cfg[r.sel]) != cpi_pkg::METH_COORD) begin
                    n.stk = r.stroke;
                end
            end
        end
        // cycle position; a step must stay smaller than the cycle length
        if (axis_step_vld_i) begin
            sum = $signed({2'b00, r.pos}) + 34'(axis_step_i);
            if (sum >= $signed({2'b00, r.len})) begin
                sum = sum - $signed({2'b00, r.len});
                wd = 8'sh01;
                n.wrp = 1'b1;
            end else if (sum < 0) begin
                sum = sum + $signed({2'b00, r.len});
                wd = -8'sh01;
                n.wrp = 1'b1;
            end
            n.pos = sum[31:0];
        end
        n.wcnt = r.wcnt + wd;
        case (r.st)
            cpi_pkg::ST_IDLE: begin
                if (r.wcnt != 8'sh00) begin
                    n.job = cpi_pkg::JOB_WL;
                    n.q = r.len;
                    n.wneg = r.wcnt[7];
                    n.wcnt = r.wcnt + wd + (r.wcnt[7] ? 8'sh01 : -8'sh01);
                end else begin
                    n.job = cpi_pkg::JOB_FEED;
                    n.q = r.pos;
                end
                n.ph = cpi_pkg::PH_START;
                n.st = cpi_pkg::ST_LOAD;
            end
            cpi_pkg::ST_LOAD: begin
                case (r.ph)
                    cpi_pkg::PH_START: begin
                        if (r.cam == 4'h0) begin
                            num = $signed({32'h0, r.q}) * cpi_pkg::RATIO_FULL;
                            den = {32'h0, r.len};
                            n.ph = cpi_pkg::PH_RAT;
                            go = 1'b1;
                        end else if (meth(ccfg) == cpi_pkg::METH_STROKE) begin
                            num = $signed({32'h0, r.q}) * $signed({52'h0, res_n});
                            den = {32'h0, r.len};
                            n.ph = cpi_pkg::PH_IDX;
                            go = 1'b1;
                        end else if (meth(ccfg) == cpi_pkg::METH_COORD) begin
                            n.idx = '0;
                            n.st = cpi_pkg::ST_SCAN;
                        end else begin
                            n.acc = '0;
                            n.st = cpi_pkg::ST_DONE;
                        end
                    end
                    cpi_pkg::PH_IDX: begin
                        k = r.dvd[12:0] + {2'b00, start};
                        r0 = tval(k);
                        r1 = tval(k + 13'h0001);
                        n.acc = 64'(r0);
                        num = 64'(r1 - r0) * $signed(r.rem);
                        den = {32'h0, r.len};
                        n.ph = cpi_pkg::PH_FRAC;
                        go = 1'b1;
                    end
                    cpi_pkg::PH_FRAC: begin
                        n.ph = cpi_pkg::PH_RAT;
                        n.dvd = 64'(r.acc + qs);
                        n.neg = 1'b0;
                    end
                    cpi_pkg::PH_RAT: begin
                        num = 64'(r.stk) * qs;
                        den = cpi_pkg::RATIO_FULL;
                        n.ph = cpi_pkg::PH_VAL;
                        go = 1'b1;
                    end
                    cpi_pkg::PH_SEG: begin
                        n.acc = 64'(mem[cx + 14'h001]);
                        num = 64'(mem[cx + 14'h003] - mem[cx + 14'h001])
                            * ($signed({32'h0, r.q}) * cpi_pkg::COORD_SCALE - 64'(mem[cx]));
                        den = 64'(mem[cx + 14'h002] - mem[cx]);
                        n.ph = cpi_pkg::PH_CY;
                        go = 1'b1;
                    end
                    cpi_pkg::PH_CY: begin
                        num = r.acc + qs;
                        den = cpi_pkg::COORD_SCALE;
                        n.ph = cpi_pkg::PH_VAL;
                        go = 1'b1;
                    end
                    default: begin
                        n.acc = qs;
                        n.st = cpi_pkg::ST_DONE;
                    end
                endcase
            end
            cpi_pkg::ST_SCAN: begin
                // first segment whose upper input lies above the position
                if ({2'b00, r.idx} + 13'h0002 < {2'b00, npts}
                    && 64'(mem[cx + 14'h002])
                    <= $signed({32'h0, r.q}) * cpi_pkg::COORD_SCALE) begin
                    n.idx = r.idx + 11'h001;
                end else begin
                    n.ph = cpi_pkg::PH_SEG;
                    n.st = cpi_pkg::ST_LOAD;
                end
            end
            cpi_pkg::ST_DIV: begin
                tr = {r.rem, r.dvd[63]} - {1'b0, r.dvs};
                n.dvd = {r.dvd[62:0], !tr[64]};
                n.rem = tr[64] ? {r.rem[62:0], r.dvd[63]} : tr[63:0];
                n.cnt = r.cnt - 7'h01;
                if (r.cnt == 7'h01) begin
                    n.st = cpi_pkg::ST_LOAD;
                end
            end
            cpi_pkg::ST_DONE: begin
                n.st = cpi_pkg::ST_IDLE;
                case (r.job)
                    cpi_pkg::JOB_WL: begin
                        n.tmp = r.acc[31:0];
                        n.job = cpi_pkg::JOB_W0;
                        n.q = '0;
                        n.ph = cpi_pkg::PH_START;
                        n.st = cpi_pkg::ST_LOAD;
                    end
                    cpi_pkg::JOB_W0: begin
                        // end-of-cycle value minus start value, both kinds
                        n.std = r.wneg ? r.std - (r.tmp - r.acc[31:0])
                            : r.std + (r.tmp - r.acc[31:0]);
                    end
                    default: begin
                        n.feed = r.std + r.acc[31:0];
                        n.fvld = 1'b1;
                    end
                endcase
            end
            default: n.st = cpi_pkg::ST_IDLE;
        endcase
        if (go) begin
            n.neg = num[63];
            n.dvd = num[63] ? 64'(-num) : 64'(num);
            n.dvs = (den == 64'h0) ? 64'h1 : den;
            n.rem = '0;
            n.cnt = cpi_pkg::DIV_STEPS;
            n.st = cpi_pkg::ST_DIV;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
            r.st <= cpi_pkg::ST_IDLE;
            r.len <= cpi_pkg::LEN_RST;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (apb_wr && paddr_i == cpi_pkg::OFF_TDATA) begin
            mem[r.taddr] <= pwdata_i;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_cmd_latch_cam: assert property (rise && r.sel <= 4'h8 |=> r.cam == $past(r.sel))
        else $error("cam not latched on command");
    a_bad_cam_err: assert property (rise && r.sel > 4'h8 |=> r.err && $stable(r.cam))
        else $error("invalid cam accepted");
    a_coord_keep_stk: assert property (rise && r.sel != 4'h0 && r.sel <= 4'h8
        && meth(r.cfg[r.sel]) == cpi_pkg::METH_COORD |=> $stable(r.stk))
        else $error("stroke latched in coordinate mode");
    a_wrap_fwd: assert property (axis_step_vld_i && !axis_step_i[31] && r.len != 0
        && {1'b0, r.pos} + {1'b0, axis_step_i} >= {1'b0, r.len}
        |=> wrap_o && r.pos < r.len ##1 !wrap_o || $past(axis_step_vld_i, 1))
        else $error("forward wrap missed");
    a_std_only_wrap: assert property (r.std != $past(r.std)
        |-> $past(r.st) == cpi_pkg::ST_DONE && $past(r.job) == cpi_pkg::JOB_W0)
        else $error("standard position moved outside wrap");
    a_linear_full: assert property (r.st == cpi_pkg::ST_DONE && r.cam == 4'h0
        && r.job == cpi_pkg::JOB_WL |-> r.acc[31:0] == r.stk)
        else $error("linear cam not 100 percent at end");
    a_feed_sum: assert property (r.st == cpi_pkg::ST_DONE && r.job == cpi_pkg::JOB_FEED
        |=> feed_vld_o && feed_pos_o == $past(r.std + r.acc[31:0]))
        else $error("feed position wrong");
    a_idx_range: assert property (r.st == cpi_pkg::ST_LOAD && r.ph == cpi_pkg::PH_IDX
        |-> r.dvd <= {52'h0, res_n})
        else $error("stroke index beyond resolution");
    a_div_len: assert property (r.st == cpi_pkg::ST_DIV && r.cnt == cpi_pkg::DIV_STEPS
        |-> ##63 r.st == cpi_pkg::ST_DIV ##1 r.st == cpi_pkg::ST_LOAD)
        else $error("divider length wrong");
    a_scan_bound: assert property (r.st == cpi_pkg::ST_SCAN
        |-> {2'b00, r.idx} + 13'h0002 <= {2'b00, npts} || npts < 11'h002)
        else $error("scan left the table");

    c_cmd_latch: cover property (rise && r.sel != 4'h0 && r.sel <= 4'h8);
    c_wrap_std: cover property (r.st == cpi_pkg::ST_DONE && r.job == cpi_pkg::JOB_W0);
    c_coord_feed: cover property (r.st == cpi_pkg::ST_SCAN ##[1:200] feed_vld_o);
    c_bad_cam: cover property (rise && r.sel > 4'h8);
endmodule

// ### cpi_apb_master.sv
// apb master model standing in for the network master
`timescale 1ns/1ps
module cpi_apb_master (
    input wire logic core_clk_i,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0000_0000;
    end

    // request held until pready is seen high at a rising edge, or until 64 edges pass with the transfer marked late
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic late);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= w ? d : ~d;
        @(posedge core_clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 64);
        q = prdata_i;
        err = pslverr_i;
        late = (n >= 64);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule

// ### cam_profile_interpolator_test.sv
// self-checking testbench for the cam profile interpolator
`timescale 1ns/1ps
module cam_profile_interpolator_test;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, feed_vld, wrap, e, late;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cyc_pos, feed, std, q;
    logic signed [31:0] step = 32'sh0;
    logic step_vld = 1'b0;
    integer seed = 33;
    int n_mismatch = 0;
    int cmp_count = 0;
    int len, pos, exp_std, s, t, k;
    int tbl [256];

    always #2.5 core_clk_i = ~core_clk_i;

    cpi_apb_master cpi_apb_master_i (.core_clk_i(core_clk_i), .prdata_i(prdata),
        .pready_i(pready), .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    cpi_cam_interp cpi_cam_interp_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .axis_step_i(step),
        .axis_step_vld_i(step_vld), .cyc_pos_o(cyc_pos), .feed_pos_o(feed),
        .feed_vld_o(feed_vld), .wrap_o(wrap), .std_pos_o(std));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        cmp_count++;
        if (y !== x) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        cpi_apb_master_i.xfer(w, a, d, q, e, late);
        if (late) begin
            n_mismatch++;
            test_done();
        end
    endtask
    task automatic wait_feed(input int n);
        int c;
        for (int i = 0; i < n; i++) begin
            c = 0;
            do begin
                @(posedge core_clk_i);
                c++;
            end while (feed_vld !== 1'b1 && c < 1000);
            if (c >= 1000) begin
                n_mismatch++;
                test_done();
            end
        end
    endtask
    task automatic cmd(input logic [31:0] sel, input logic [31:0] stk);
        acc(1'b1, cpi_pkg::OFF_CAMSEL, sel);
        acc(1'b1, cpi_pkg::OFF_STROKE, stk);
        acc(1'b1, cpi_pkg::OFF_CTRL, 32'h0);
        acc(1'b1, cpi_pkg::OFF_CTRL, 32'h1);
        wait_feed(4);
    endtask
    task automatic move(input int d, input int to, input logic w);
        @(posedge core_clk_i);
        step <= d;
        step_vld <= 1'b1;
        @(posedge core_clk_i);
        step_vld <= 1'b0;
        #1;
        chk("cyc_pos", to, cyc_pos);
        chk("wrap", w, wrap);
        pos = to;
    endtask
    task automatic wrap_to(input int to);
        move(len - 1 - pos, len - 1, 1'b0);
        move(to + 1, to, 1'b1);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        acc(1'b0, cpi_pkg::OFF_LEN, 32'h0);
        chk("len_rst", cpi_pkg::LEN_RST, q);
        acc(1'b0, 12'h200, 32'h0);
        chk("unmapped_err", 32'h1, e);
        chk("unmapped_data", 32'h0, q);
        $display("test reset_map done");
        len = 1000;
        pos = 0;
        exp_std = 0;
        acc(1'b1, cpi_pkg::OFF_LEN, len);
        for (k = 0; k < 3; k++) begin
            s = ($random(seed) % 5) * 1000;
            cmd(32'h0, s);
            t = $unsigned($random(seed)) % 999;
            move(t - pos, t, 1'b0);
            wait_feed(4);
            chk("lin_feed", exp_std + s * t / 1000, feed);
            wrap_to($unsigned($random(seed)) % 500);
            exp_std += s;
            wait_feed(6);
            chk("lin_std", exp_std, std);
        end
        $display("test linear_cam done");
        // pending selection must not act before the command rises
        acc(1'b1, cpi_pkg::OFF_CAMSEL, 32'h1);
        acc(1'b0, cpi_pkg::OFF_STATUS, 32'h0);
        chk("cam_held", 32'h0, q[4:1]);
        cmd(32'h9, 32'h0);
        acc(1'b0, cpi_pkg::OFF_STATUS, 32'h0);
        chk("bad_sel_err", 32'h1, q[0]);
        chk("bad_sel_cam", 32'h0, q[4:1]);
        acc(1'b1, cpi_pkg::OFF_STATUS, 32'h1);
        $display("test command_latch done");
        len = 1024;
        acc(1'b1, cpi_pkg::OFF_LEN, len);
        acc(1'b1, cpi_pkg::OFF_CFG1, 32'h1);
        acc(1'b1, cpi_pkg::OFF_TADDR, 32'h0);
        for (k = 0; k < 256; k++) begin
            tbl[k] = ($random(seed) % 50000) * 2;
            acc(1'b1, cpi_pkg::OFF_TDATA, tbl[k]);
        end
        cmd(32'h1, 100000);
        for (k = 0; k < 4; k++) begin
            t = $unsigned($random(seed)) % 255;
            move(4 * t + 2 - pos, 4 * t + 2, 1'b0);
            wait_feed(4);
            chk("tbl_feed", exp_std + (tbl[t] + tbl[t + 1]) / 2, feed);
        end
        $display("test stroke_table done");
        acc(1'b1, cpi_pkg::OFF_CFG1 + 12'h004, 32'h2 | (32'h2 << 15));
        acc(1'b1, cpi_pkg::OFF_TADDR, 32'h800);
        acc(1'b1, cpi_pkg::OFF_TDATA, 256000);
        acc(1'b1, cpi_pkg::OFF_TDATA, 0);
        acc(1'b1, cpi_pkg::OFF_TDATA, 768000);
        acc(1'b1, cpi_pkg::OFF_TDATA, 512000);
        cmd(32'h2, 32'h7);
        move(10 - pos, 10, 1'b0);
        wait_feed(4);
        chk("crd_feed", exp_std - 246, feed);
        wrap_to(6);
        exp_std += 1024;
        wait_feed(6);
        chk("crd_std", exp_std, std);
        chk("crd_feed_wrap", exp_std - 250, feed);
        $display("test coordinate done");
        test_done();
    end
endmodule
